// ### common/cbe_pkg.sv
// constants shared by both ends of the byte checksum engine
package cbe_pkg;
   // byte-wide register map of the checksum unit
   localparam logic [2:0] SFR_INPUT = 3'h0;
   localparam logic [2:0] SFR_DATA = 3'h1;
   localparam logic [2:0] SFR_CTRL = 3'h2;
   localparam logic [2:0] SFR_AUTO = 3'h3;
   localparam logic [2:0] SFR_COUNT = 3'h4;
   localparam logic [2:0] SFR_FLIP = 3'h5;
   // control register fields
   localparam int CTRL_SEL_BIT = 4;
   localparam int CTRL_INIT_BIT = 3;
   localparam int CTRL_VAL_BIT = 2;
   localparam int CTRL_PNT_LSB = 0;
   // auto flash control fields
   localparam int AUTO_EN_BIT = 7;
   localparam int PAGE_W = 6;
   localparam int COUNT_W = 6;
   localparam int SECTOR_W = 10;
   localparam int SECTOR_BYTES = 1024;
   localparam int FLASH_ADDR_W = PAGE_W + SECTOR_W;
   localparam int BYTES_LEFT_W = COUNT_W + SECTOR_W + 1;
   // polynomials and start values
   localparam logic [15:0] POLY16 = 16'h1021;
   localparam logic [31:0] POLY32_REFLECTED = 32'hEDB88320;
   localparam logic [31:0] INIT_ZEROS = 32'h00000000;
   localparam logic [31:0] INIT_ONES = 32'hFFFFFFFF;
   localparam int BITS_PER_BYTE = 8;
   // reset values
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [31:0] WORD_RESET = 32'h00000000;
   // host registers on the APB side
   localparam logic [7:0] APB_CMD = 8'h00;
   localparam logic [7:0] APB_STATUS = 8'h04;
   localparam int CMD_ADDR_LSB = 8;
   localparam int CMD_WRITE_BIT = 16;
   localparam int STAT_PEND_BIT = 0;
   localparam int STAT_BUSY_BIT = 1;
   localparam int STAT_DATA_LSB = 8;
   // auto run states
   typedef enum logic [0:0]
   {
      CBE_IDLE = 1'b0,
      CBE_RUN = 1'b1
   } cbe_state_t;
endpackage

// ### common/cbe_sfr_if.sv
// byte register port between controller and checksum unit
`timescale 1ns/1ps
interface cbe_sfr_if;
   logic [2:0] sfrAddr;
   logic [7:0] sfrWdata;
   logic sfrWr;
   logic sfrRd;
   logic [7:0] sfrRdata;
   logic sfrBusy;
   modport device
   (
      input sfrAddr,
      input sfrWdata,
      input sfrWr,
      input sfrRd,
      output sfrRdata,
      output sfrBusy
   );
   modport host
   (
      output sfrAddr,
      output sfrWdata,
      output sfrWr,
      output sfrRd,
      input sfrRdata,
      input sfrBusy
   );
endinterface

// ### testbench/cbe_asserts.sv
// concurrent checks on the byte register port between the two ends
`timescale 1ns/1ps
module cbe_asserts
   import cbe_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [2:0] sfrAddr,
   input wire logic [7:0] sfrWdata,
   input wire logic sfrWr,
   input wire logic sfrRd,
   input wire logic [7:0] sfrRdata,
   input wire logic sfrBusy
);
   import cbe_pkg::*;

   logic auto_flash_enable_q;
   logic [5:0] count_q;
   logic [7:0] flip_q;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // shadow of host writes, so a start can be predicted from the port alone
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         auto_flash_enable_q <= 1'b0;
         count_q <= 6'h00;
         flip_q <= 8'h00;
      end
      else if (sfrWr)
      begin
         if (sfrAddr == SFR_AUTO) auto_flash_enable_q <= sfrWdata[AUTO_EN_BIT];
         if (sfrAddr == SFR_COUNT) count_q <= sfrWdata[5:0];
         if (sfrAddr == SFR_FLIP) flip_q <= {<<{sfrWdata}};
      end
   end
   sequence sRead(logic [2:0] a);
      sfrRd && sfrAddr == a;
   endsequence
   sequence sCtrlWr;
      sfrWr && sfrAddr == SFR_CTRL && !sfrBusy;
   endsequence
   AST_ONE_KIND: assert property (!(sfrWr && sfrRd)) else $error("read and write strobes together");
   AST_WR_PULSE: assert property (sfrWr |=> !sfrWr) else $error("write strobe too long");
   AST_RD_PULSE: assert property (sfrRd |=> !sfrRd) else $error("read strobe too long");
   AST_QUIET_BUSY: assert property (sfrBusy |-> !sfrWr && !sfrRd) else $error("access during run");
   AST_IN_READ_ZERO: assert property (sRead(SFR_INPUT) |=> sfrRdata == 8'h00) else $error("input reg read");
   AST_CTRL_TOP_ZERO: assert property (sRead(SFR_CTRL) |=> sfrRdata[7:5] == 3'h0 && !sfrRdata[CTRL_INIT_BIT])
      else $error("control unused bits");
   AST_FLIP_READ: assert property (sRead(SFR_FLIP) |=> sfrRdata == flip_q) else $error("reverse reg");
   AST_RDATA_HOLD: assert property (!sfrRd |=> $stable(sfrRdata)) else $error("read data moved");
   AST_AUTO_START: assert property (sCtrlWr ##0 (auto_flash_enable_q && count_q != 6'h00) |=> sfrBusy)
      else $error("run not started");
   AST_NO_START: assert property (sCtrlWr ##0 (!auto_flash_enable_q || count_q == 6'h00) |=> !sfrBusy)
      else $error("run started wrongly");
endmodule

// ### testbench/cbe_tb.sv
// self-checking bench: apb master, flash stub and checksum model
`timescale 1ns/1ps
module cbe_tb;
   import cbe_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic flashReq;
   logic [FLASH_ADDR_W-1:0] flashAddr;
   logic [7:0] flashData;
   logic flashAck = 1'b0;
   int n_errors = 0;
   int checks_done = 0;
   int acksLeft = 0;
   int unsigned expAddr = 0;
   logic [31:0] crc;
   logic [31:0] r;
   logic err;
   logic [7:0] q;
   cbe_sfr_if sfrBus();
   cbe_host cbe_host_i(.clock(clock), .rst(rst), .sfr(sfrBus), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   cbe_device cbe_device_i(.clock(clock), .rst(rst), .sfr(sfrBus), .flashReq(flashReq), .flashAddr(flashAddr),
      .flashData(flashData), .flashAck(flashAck));
   cbe_asserts cbe_asserts_i(.clock(clock), .rst(rst), .sfrAddr(sfrBus.sfrAddr), .sfrWdata(sfrBus.sfrWdata),
      .sfrWr(sfrBus.sfrWr), .sfrRd(sfrBus.sfrRd), .sfrRdata(sfrBus.sfrRdata), .sfrBusy(sfrBus.sfrBusy));
   always #12.5 clock = ~clock;
   // flash content changes with every address, so a skipped byte shows
   assign flashData = flashAddr[7:0] ^ flashAddr[15:8] ^ 8'hA5;
   always @(posedge clock)
   begin
      if (flashReq === 1'b1 && flashAck === 1'b1)
      begin
         cmp(flashAddr, expAddr);
         expAddr++;
      end
      if (flashReq === 1'b1 && acksLeft > 0 && $urandom % 2)
      begin
         flashAck <= 1'b1;
         acksLeft--;
      end
      else
         flashAck <= 1'b0;
   end
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic timeout();
      n_errors++;
      final_report();
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) timeout();
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // one byte register access, then wait until the host has finished it
   task automatic sfr(input logic w, input logic [2:0] a, input logic [7:0] d);
      apb(1'b1, APB_CMD, {15'h0000, w, 5'h00, a, d});
      for (int i = 0; i < 20; i++)
      begin
         apb(1'b0, APB_STATUS, 32'h00000000);
         if (r[STAT_PEND_BIT] === 1'b0) break;
      end
      if (r[STAT_PEND_BIT] !== 1'b0) timeout();
      q = r[15:8];
   endtask
   function automatic logic [31:0] upd(logic [31:0] c, logic [7:0] b, bit m16);
      c = m16 ? c ^ {16'h0000, b, 8'h00} : c ^ {24'h000000, b};
      for (int i = 0; i < 8; i++)
      begin
         if (m16)
            c = c[15] ? {c[30:0], 1'b0} ^ 32'h00001021 : {c[30:0], 1'b0};
         else
            c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
      end
      return m16 ? c & 32'h0000FFFF : c;
   endfunction
   task automatic start(bit m16, bit ones);
      sfr(1'b1, SFR_CTRL, {3'h0, m16, 1'b1, ones, 2'h0});
      crc = ones ? (m16 ? 32'h0000FFFF : 32'hFFFFFFFF) : 32'h00000000;
   endtask
   task automatic feed(logic [7:0] b, bit m16);
      sfr(1'b1, SFR_INPUT, b);
      crc = upd(crc, b, m16);
   endtask
   // reads every result byte from pointer p on; pointer must end where it began
   task automatic check(bit m16, logic [1:0] p);
      // random top bits: they must neither stick nor read back
      sfr(1'b1, SFR_CTRL, {3'($urandom), m16, 2'h0, p});
      for (int i = 0; i < (m16 ? 2 : 4); i++)
      begin
         sfr(1'b0, SFR_DATA, 8'h00);
         cmp(q, 8'(crc >> (8 * ((p + i) % (m16 ? 2 : 4)))));
      end
      sfr(1'b0, SFR_CTRL, 8'h00);
      cmp(q, {3'h0, m16, 2'h0, p});
   endtask
   initial
   begin
      logic [7:0] b;
      logic [7:0] e;
      logic [31:0] base;
      b = 8'($urandom(32'h30D2));
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      apb(1'b0, APB_STATUS, 32'h00000000);
      cmp(r, 32'h00000000);
      cmp(err, 1'b0);
      crc = 32'h00000000;
      check(1'b0, 2'h0);
      for (int m = 0; m < 2; m++)
      begin
         start(m[0], 1'b1);
         feed(8'h63, m[0]);
         cmp(crc, m ? 32'h0000BD35 : 32'hF9462090);
         check(m[0], 2'h0);
         start(m[0], 1'b1);
         feed(8'hAA, m[0]);
         feed(8'hBB, m[0]);
         feed(8'hCC, m[0]);
         cmp(crc, m ? 32'h00006CF6 : 32'h41B207B3);
         check(m[0], 2'h1);
      end
      for (int k = 0; k < 4; k++)
      begin
         start(k[1], k[0]);
         repeat (1 + $urandom % 6) feed(8'($urandom), k[1]);
         check(k[1], k[1] ? 2'h1 : 2'h2);
      end
      sfr(1'b1, SFR_CTRL, 8'h00);
      for (int i = 0; i < 4; i++)
      begin
         b = 8'($urandom);
         sfr(1'b1, SFR_DATA, b);
         crc[8*i +: 8] = b;
      end
      feed(8'($urandom), 1'b0);
      check(1'b0, 2'h3);
      b = 8'($urandom);
      e = {<<{b}};
      sfr(1'b1, SFR_FLIP, b);
      sfr(1'b0, SFR_FLIP, 8'h00);
      cmp(q, e);
      apb(1'b0, APB_CMD, 32'h00000000);
      cmp(r, {16'h0000, 5'h00, SFR_FLIP, 8'h00});
      sfr(1'b0, SFR_INPUT, 8'h00);
      cmp(q, 8'h00);
      apb(1'b0, 8'h08, 32'h00000000);
      cmp(err, 1'b1);
      cmp(r, 32'h00000000);
      start(1'b0, 1'b1);
      b = 8'($urandom % 64);
      sfr(1'b1, SFR_AUTO, {2'h2, b[5:0]});
      sfr(1'b0, SFR_AUTO, 8'h00);
      cmp(q, {2'h2, b[5:0]});
      sfr(1'b1, SFR_CTRL, 8'h00);
      apb(1'b0, APB_STATUS, 32'h00000000);
      cmp(r[STAT_BUSY_BIT], 1'b0);
      sfr(1'b1, SFR_COUNT, 8'h01);
      sfr(1'b0, SFR_COUNT, 8'h00);
      cmp(q, 8'h01);
      base = b[5:0] * SECTOR_BYTES;
      for (int i = 0; i < 1024; i++) crc = upd(crc, 8'(base + i) ^ 8'((base + i) >> 8) ^ 8'hA5, 1'b0);
      expAddr = base;
      acksLeft = 1024;
      sfr(1'b1, SFR_CTRL, 8'h00);
      for (int i = 0; i < 2000; i++)
      begin
         apb(1'b0, APB_STATUS, 32'h00000000);
         if (r[STAT_BUSY_BIT] === 1'b0) break;
      end
      if (r[STAT_BUSY_BIT] !== 1'b0) timeout();
      cmp(r[STAT_BUSY_BIT], 1'b0);
      cmp(flashReq, 1'b0);
      cmp(acksLeft, 0);
      sfr(1'b1, SFR_AUTO, 8'h00);
      check(1'b0, 2'h0);
      final_report();
   end
endmodule

// ### verilog/cbe_device.sv
// checksum unit: byte registers, result pointer, auto flash run
`timescale 1ns/1ps
// Operation
// R01 - 16-bit mode: msb first, poly 0x1021
// R02 - 16-bit: xor byte into upper eight bits
// R03 - shift left eight times, xor poly on carry
// R04 - 16-bit reference results must match
// R05 - 32-bit mode: reflected 0x04C11DB7 polynomial
// R06 - 32-bit: xor byte into low eight bits
// R07 - shift right eight times, xor 0xEDB88320
// R08 - 32-bit reference results from all ones
// R09 - select bit: clear 32-bit, set 16-bit
// R10 - value bit: clear zeros, set all ones
// R11 - init bit loads whole result
// R12 - each input byte write updates result
// R13 - software writes page, then auto enable
// R14 - sector count, 1024 bytes each
// R15 - control write starts auto run, core stalls
// R16 - clear auto enable before reading result
// R17 - width per mode, pointer increments per access
// R18 - result holds until init, write, input; code also folds flash bytes into it during an auto run
// R19 - separate bit reverse register
// R20 - pointer 0..3 selects result bytes 0..3
// R21 - control bits 7..5 read zero
// R22 - 16-bit references assume all-ones start
module cbe_device
   import cbe_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   cbe_sfr_if.device sfr,
   output logic flashReq,
   output logic [cbe_pkg::FLASH_ADDR_W-1:0] flashAddr,
   input wire logic [7:0] flashData,
   input wire logic flashAck
);
   import cbe_pkg::*;

   logic [31:0] result_q;
   logic [31:0] stepOut;
   logic sel16_q;
   logic initOnes_q;
   logic [1:0] pnt_q;
   logic [1:0] pntNext;
   logic auto_flash_enable_q;
   logic [PAGE_W-1:0] page_q;
   logic [COUNT_W-1:0] count_q;
   logic [7:0] flip_q;
   logic [7:0] rdata_q;
   logic busy_q;
   logic flashReq_q;
   logic [FLASH_ADDR_W-1:0] flashAddr_q;
   logic [BYTES_LEFT_W-1:0] bytesLeft_q;
   cbe_state_t state_q;
   logic [7:0] stepByte;
   logic wrInput;
   logic wrData;
   logic rdData;
   logic wrCtrl;
   logic startRun;
   logic foldFlash;
   logic [7:0] ctrlRead;
   logic [7:0] dataByte;

   assign wrInput = sfr.sfrWr && (sfr.sfrAddr == SFR_INPUT);
   assign wrData = sfr.sfrWr && (sfr.sfrAddr == SFR_DATA);
   assign rdData = sfr.sfrRd && (sfr.sfrAddr == SFR_DATA);
   assign wrCtrl = sfr.sfrWr && (sfr.sfrAddr == SFR_CTRL);
   // any control write with auto enabled and a nonzero count starts the run when idle, even an unchanged value
   assign startRun = wrCtrl && auto_flash_enable_q && (count_q != '0) && (state_q == CBE_IDLE); // R15
   assign foldFlash = (state_q == CBE_RUN) && flashAck;
   // in 16-bit mode only bytes 0 and 1 exist
   assign pntNext = sel16_q ? {1'b0, ~pnt_q[0]} : pnt_q + 2'd1; // R17
   assign dataByte = result_q[pnt_q*8 +: 8]; // R20
   assign ctrlRead = {3'b000, sel16_q, 1'b0, initOnes_q, pnt_q}; // R21
   // the engine is shared: the core is stalled while flash bytes flow
   assign stepByte = (state_q == CBE_RUN) ? flashData : sfr.sfrWdata;

   cbe_step u_step
   (
      .crcIn(result_q),
      .dataIn(stepByte),
      .sel16(sel16_q),
      .crcOut(stepOut)
   );

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         sel16_q <= 1'b0;
         initOnes_q <= 1'b0;
      end
      else if (wrCtrl)
      begin
         sel16_q <= sfr.sfrWdata[CTRL_SEL_BIT]; // R09
         initOnes_q <= sfr.sfrWdata[CTRL_VAL_BIT]; // R10
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
         pnt_q <= 2'b00;
      else if (wrCtrl)
         pnt_q <= sfr.sfrWdata[CTRL_PNT_LSB +: 2];
      else if (wrData || rdData)
         pnt_q <= pntNext; // R17
   end

   // result: init, data port overwrite, or one byte folded in
   always_ff @(posedge clock)
   begin
      if (rst)
         result_q <= WORD_RESET;
      else if (foldFlash)
         result_q <= stepOut; // R14
      else if (wrCtrl && sfr.sfrWdata[CTRL_INIT_BIT])
      begin
         // new value and select apply in the same write
         if (sfr.sfrWdata[CTRL_VAL_BIT])
            result_q <= INIT_ONES; // R11 R10 R22
         else
            result_q <= INIT_ZEROS; // R11
      end
      else if (wrData)
         result_q[pnt_q*8 +: 8] <= sfr.sfrWdata; // R18 R20
      else if (wrInput)
         result_q <= stepOut; // R12 R04 R08
   end

   always_ff @(posedge clock)
   begin
      if (rst)
         flip_q <= BYTE_RESET;
      else if (sfr.sfrWr && (sfr.sfrAddr == SFR_FLIP))
         flip_q <= {<<{sfr.sfrWdata}}; // R19
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         auto_flash_enable_q <= 1'b0;
         page_q <= '0;
      end
      else if (sfr.sfrWr && (sfr.sfrAddr == SFR_AUTO))
      begin
         auto_flash_enable_q <= sfr.sfrWdata[AUTO_EN_BIT]; // R13 R16
         page_q <= sfr.sfrWdata[PAGE_W-1:0]; // R13
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
         count_q <= '0;
      else if (sfr.sfrWr && (sfr.sfrAddr == SFR_COUNT))
         count_q <= sfr.sfrWdata[COUNT_W-1:0]; // R14
   end

   // auto flash run: one byte per acknowledged request
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         state_q <= CBE_IDLE;
         busy_q <= 1'b0;
         flashReq_q <= 1'b0;
         flashAddr_q <= '0;
         bytesLeft_q <= '0;
      end
      else
      begin
         case (state_q)
            CBE_IDLE:
            begin
               if (startRun)
               begin
                  state_q <= CBE_RUN;
                  busy_q <= 1'b1; // R15
                  flashReq_q <= 1'b1;
                  flashAddr_q <= {page_q, {SECTOR_W{1'b0}}};
                  bytesLeft_q <= {1'b0, count_q, {SECTOR_W{1'b0}}}; // R14
               end
            end
            CBE_RUN:
            begin
               if (flashAck)
               begin
                  flashAddr_q <= flashAddr_q + 1'b1;
                  bytesLeft_q <= bytesLeft_q - 1'b1;
                  if (bytesLeft_q == BYTES_LEFT_W'(1))
                  begin
                     state_q <= CBE_IDLE;
                     busy_q <= 1'b0;
                     flashReq_q <= 1'b0;
                  end
               end
            end
            default:
            begin
               state_q <= CBE_IDLE;
               busy_q <= 1'b0;
               flashReq_q <= 1'b0;
            end
         endcase
      end
   end

   // read data is registered; unused addresses read zero
   always_ff @(posedge clock)
   begin
      if (rst)
         rdata_q <= BYTE_RESET;
      else if (sfr.sfrRd)
      begin
         case (sfr.sfrAddr)
            SFR_DATA: rdata_q <= dataByte; // R17 R20
            SFR_CTRL: rdata_q <= ctrlRead; // R21
            SFR_AUTO: rdata_q <= {auto_flash_enable_q, 1'b0, page_q};
            SFR_COUNT: rdata_q <= {2'b00, count_q};
            SFR_FLIP: rdata_q <= flip_q; // R19
            default: rdata_q <= BYTE_RESET;
         endcase
      end
   end

   assign sfr.sfrRdata = rdata_q;
   assign sfr.sfrBusy = busy_q;
   assign flashReq = flashReq_q;
   assign flashAddr = flashAddr_q;
endmodule

// ### verilog/cbe_host.sv
// controller: APB registers turned into byte register accesses
`timescale 1ns/1ps
module cbe_host
   import cbe_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   cbe_sfr_if.host sfr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   import cbe_pkg::*;

   logic pready_q;
   logic [31:0] prdata_q;
   logic pslverr_q;
   logic pend_q;
   logic [2:0] addr_q;
   logic [7:0] wdata_q;
   logic isWrite_q;
   logic wr_q;
   logic rd_q;
   logic rdWait_q;
   logic [7:0] lastRead_q;
   logic setup;
   logic done;
   logic issue;
   logic [31:0] status;

   assign setup = psel && penable && !pready_q;
   assign done = psel && penable && pready_q;
   // core stall: nothing is issued while an auto run holds the unit
   assign issue = pend_q && !sfr.sfrBusy; // R15
   assign status = {16'h0000, lastRead_q, 6'b000000,
                    sfr.sfrBusy, pend_q | wr_q | rd_q | rdWait_q};

   // one wait state on every transfer
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         pready_q <= 1'b0;
         prdata_q <= WORD_RESET;
         pslverr_q <= 1'b0;
      end
      else
      begin
         pready_q <= setup;
         pslverr_q <= setup && (paddr != APB_CMD) && (paddr != APB_STATUS);
         if (setup && !pwrite && (paddr == APB_STATUS))
            prdata_q <= status;
         else if (setup && !pwrite && (paddr == APB_CMD))
            prdata_q <= {15'h0000, isWrite_q, 5'b00000, addr_q, wdata_q};
         else
            prdata_q <= WORD_RESET;
      end
   end

   // a command written while one is pending is dropped
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         pend_q <= 1'b0;
         addr_q <= 3'h0;
         wdata_q <= BYTE_RESET;
         isWrite_q <= 1'b0;
      end
      else if (done && pwrite && (paddr == APB_CMD) && !pend_q)
      begin
         pend_q <= 1'b1;
         addr_q <= pwdata[CMD_ADDR_LSB +: 3];
         wdata_q <= pwdata[7:0];
         isWrite_q <= pwdata[CMD_WRITE_BIT];
      end
      else if (issue)
         pend_q <= 1'b0;
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         rdWait_q <= 1'b0;
      end
      else
      begin
         wr_q <= issue && isWrite_q; // R12
         rd_q <= issue && !isWrite_q;
         rdWait_q <= rd_q;
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
         lastRead_q <= BYTE_RESET;
      else if (rdWait_q)
         lastRead_q <= sfr.sfrRdata;
   end

   assign sfr.sfrAddr = addr_q;
   assign sfr.sfrWdata = wdata_q;
   assign sfr.sfrWr = wr_q;
   assign sfr.sfrRd = rd_q;
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
endmodule

// ### verilog/cbe_step.sv
// one byte of checksum update, 16-bit msb-first or reflected 32-bit
`timescale 1ns/1ps
module cbe_step
   import cbe_pkg::*;
(
   input wire logic [31:0] crcIn,
   input wire logic [7:0] dataIn,
   input wire logic sel16,
   output logic [31:0] crcOut
);
   import cbe_pkg::*;

   logic [15:0] acc16;
   logic [31:0] acc32;
   always_comb
   begin
      acc16 = crcIn[15:0] ^ {dataIn, 8'h00}; // R02
      acc32 = crcIn ^ {24'h000000, dataIn}; // R06
      for (int i = 0; i < BITS_PER_BYTE; i++)
      begin
         if (acc16[15]) // R01 R03
            acc16 = {acc16[14:0], 1'b0} ^ POLY16;
         else
            acc16 = {acc16[14:0], 1'b0};
         if (acc32[0]) // R05 R07
            acc32 = {1'b0, acc32[31:1]} ^ POLY32_REFLECTED;
         else
            acc32 = {1'b0, acc32[31:1]};
      end
      // upper half is left alone in 16-bit mode
      crcOut = sel16 ? {crcIn[31:16], acc16} : acc32;
   end
endmodule
